// File: shared/dadc_defines.svh
`ifndef DADC_DEFINES_SVH
`define DADC_DEFINES_SVH

// Converter word and sampled input
`define DADC_W 12
`define DADC_IN_W 14
`define DADC_POS_FS 14'h07ff
`define DADC_NEG_FS 14'h3800
`define DADC_OFS 14'h0800
`define DADC_CODE_MAX 12'hfff
`define DADC_CODE_MIN 12'h000
`define DADC_MSB 11
`define DADC_LAT 3
`define DADC_NCH 2

// Register byte addresses
`define DADC_A_CTRL 32'h0000_0000
`define DADC_A_STATUS 32'h0000_0004
`define DADC_A_WORD_A 32'h0000_0008
`define DADC_A_WORD_B 32'h0000_000c

// Control register fields
`define DADC_CTRL_W 5
`define DADC_CTRL_RST 5'h00
`define DADC_CTRL_SLP_A 0
`define DADC_CTRL_SLP_B 1
`define DADC_CTRL_OVR 2
`define DADC_CTRL_LVL_LO 3
`define DADC_CTRL_LVL_HI 4

// Status register fields
`define DADC_STAT_W 6
`define DADC_STAT_SLP_A 0
`define DADC_STAT_SLP_B 1
`define DADC_STAT_TWOS 2
`define DADC_STAT_STAB 3
`define DADC_STAT_LVL_LO 4
`define DADC_STAT_LVL_HI 5
`define DADC_STAT_CLIP_A 8
`define DADC_STAT_CLIP_B 9

// Bus responses
`define DADC_RESP_OKAY 2'h0
`define DADC_RESP_SLVERR 2'h2

`endif

// File: shared/dadc_pkg.sv
package dadc_pkg;

  typedef enum logic [1:0] {
    DADC_LVL_GND = 2'b00,
    DADC_LVL_THIRD = 2'b01,
    DADC_LVL_TWOTHIRD = 2'b10,
    DADC_LVL_SUPPLY = 2'b11
  } dadc_level_t;

  typedef struct packed {
    logic sleep;
    logic twos;
  } dadc_cfg_t;

  typedef struct packed {
    dadc_level_t lvl;
    logic stab;
    logic twos;
  } dadc_mode_t;

  typedef enum logic {
    DADC_WR_IDLE = 1'b0,
    DADC_WR_RESP = 1'b1
  } dadc_wr_state_t;

  typedef enum logic {
    DADC_RD_IDLE = 1'b0,
    DADC_RD_RESP = 1'b1
  } dadc_rd_state_t;

endpackage : dadc_pkg

// File: rtl/dadc_chan.sv
`timescale 1ns/1ps
`include "dadc_defines.svh"

module dadc_chan (
  input wire logic link_clk,
  input wire logic link_rst_n,
  input wire dadc_pkg::dadc_cfg_t cfg,
  input wire logic [`DADC_IN_W-1:0] analog_in,
  output logic [`DADC_W-1:0] result_word,
  output logic clip
);

  logic [`DADC_IN_W-1:0] sample_q;
  logic [`DADC_W-1:0] pipe_q [`DADC_LAT];
  logic [`DADC_W-1:0] code_d;
  logic clip_d;
  logic [`DADC_IN_W-1:0] shifted;

  // Sample and hold on the rising clock edge
  always_ff @(posedge link_clk)
  begin
    if (!link_rst_n)
      sample_q <= '0;
    else if (!cfg.sleep)
      sample_q <= analog_in;
  end

  always_comb
  begin
    shifted = sample_q + `DADC_OFS;
    clip_d = 1'b0;
    if ($signed(sample_q) > $signed(`DADC_POS_FS))
    begin
      code_d = `DADC_CODE_MAX;
      clip_d = 1'b1;
    end
    else if ($signed(sample_q) < $signed(`DADC_NEG_FS))
    begin
      code_d = `DADC_CODE_MIN;
      clip_d = 1'b1;
    end
    else
      code_d = shifted[`DADC_W-1:0];
    if (cfg.twos)
      code_d[`DADC_MSB] = ~code_d[`DADC_MSB];
  end

  // Fixed latency from sample to word
  always_ff @(posedge link_clk)
  begin
    if (!link_rst_n || cfg.sleep)
    begin
      for (int i = 0; i < `DADC_LAT; i++)
        pipe_q[i] <= '0;
      clip <= 1'b0;
    end
    else
    begin
      pipe_q[0] <= code_d;
      for (int i = 1; i < `DADC_LAT; i++)
        pipe_q[i] <= pipe_q[i-1];
      clip <= clip_d;
    end
  end

  // Word changes with the strobe's fall
  always_ff @(negedge link_clk)
  begin
    if (!link_rst_n || cfg.sleep)
      result_word <= '0;
    else
      result_word <= pipe_q[`DADC_LAT-1];
  end

endmodule : dadc_chan

// File: rtl/dadc_top.sv
`timescale 1ns/1ps
`include "dadc_defines.svh"

module dadc_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic link_clk,
  input wire logic [`DADC_IN_W-1:0] analog_in_a,
  input wire logic [`DADC_IN_W-1:0] analog_in_b,
  input wire logic [1:0] format_stabiliser_select,
  input wire logic sleep_chan_a,
  input wire logic sleep_chan_b,
  output logic [`DADC_W-1:0] result_word_a,
  output logic [`DADC_W-1:0] result_word_b,
  output logic word_valid_strobe
);

  // Bus side state
  dadc_pkg::dadc_wr_state_t wr_state_q;
  dadc_pkg::dadc_rd_state_t rd_state_q;
  logic aw_got_q;
  logic w_got_q;
  logic [31:0] waddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic wr_fire;
  logic [`DADC_CTRL_W-1:0] ctrl_q;
  logic [1:0] clip_seen_q;
  logic [`DADC_W-1:0] snap_a_q;
  logic [`DADC_W-1:0] snap_b_q;
  logic snap_req_q;
  logic ack_s1_q;
  logic ack_s2_q;
  logic [`DADC_STAT_W-1:0] snap_stat_q;
  logic [`DADC_CTRL_W-1:0] ctrl_xfer_q;
  logic [31:0] rd_word;
  logic rd_hit;

  // Link side state
  logic lrst_s1_q;
  logic lrst_s2_q;
  logic link_rst_n;
  logic [`DADC_CTRL_W-1:0] lctrl_q;
  logic [`DADC_STAT_W-1:0] hold_stat_q;
  logic [3:0] pin_s1_q;
  logic [3:0] pin_s2_q;
  dadc_pkg::dadc_mode_t mode_q;
  logic [1:0] sleep_q;
  logic [`DADC_STAT_W-1:0] stat_q;
  logic req_s1_q;
  logic req_s2_q;
  logic link_ack_q;
  logic [`DADC_W-1:0] hold_a_q;
  logic [`DADC_W-1:0] hold_b_q;
  logic [1:0] clip_acc_q;
  logic [1:0] hold_clip_q;
  logic stb_pos_q;
  logic stb_neg_q;
  dadc_pkg::dadc_level_t lvl_sel;
  logic [`DADC_IN_W-1:0] ch_in [`DADC_NCH];
  logic [`DADC_W-1:0] ch_word [`DADC_NCH];
  logic [`DADC_NCH-1:0] ch_clip;

  assign wr_fire = (wr_state_q == dadc_pkg::DADC_WR_IDLE) && aw_got_q && w_got_q;

  // Write address, data and response
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wr_state_q <= dadc_pkg::DADC_WR_IDLE;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `DADC_RESP_OKAY;
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      waddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end
    else
    begin
      case (wr_state_q)
        dadc_pkg::DADC_WR_IDLE:
        begin
          if (s_axi_awvalid && s_axi_awready)
          begin
            waddr_q <= s_axi_awaddr;
            aw_got_q <= 1'b1;
            s_axi_awready <= 1'b0;
          end
          else if (!aw_got_q)
            s_axi_awready <= 1'b1;
          if (s_axi_wvalid && s_axi_wready)
          begin
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
            w_got_q <= 1'b1;
            s_axi_wready <= 1'b0;
          end
          else if (!w_got_q)
            s_axi_wready <= 1'b1;
          if (wr_fire)
          begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            wr_state_q <= dadc_pkg::DADC_WR_RESP;
            if ({waddr_q[31:2], 2'b00} == `DADC_A_CTRL || {waddr_q[31:2], 2'b00} == `DADC_A_STATUS)
              s_axi_bresp <= `DADC_RESP_OKAY;
            else
              s_axi_bresp <= `DADC_RESP_SLVERR;
          end
        end
        dadc_pkg::DADC_WR_RESP:
        begin
          if (s_axi_bready)
          begin
            s_axi_bvalid <= 1'b0;
            wr_state_q <= dadc_pkg::DADC_WR_IDLE;
          end
        end
        default:
          wr_state_q <= dadc_pkg::DADC_WR_IDLE;
      endcase
    end
  end

  // Control register, byte lane 0 only
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ctrl_q <= `DADC_CTRL_RST;
    else if (wr_fire && {waddr_q[31:2], 2'b00} == `DADC_A_CTRL && wstrb_q[0])
      ctrl_q <= wdata_q[`DADC_CTRL_W-1:0];
  end

  // Sticky clip flags, new clip beats write-one-to-clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      clip_seen_q <= '0;
    else
    begin
      for (int i = 0; i < `DADC_NCH; i++)
      begin
        if (ack_s2_q == snap_req_q && hold_clip_q[i])
          clip_seen_q[i] <= 1'b1;
        else if (wr_fire && {waddr_q[31:2], 2'b00} == `DADC_A_STATUS && wstrb_q[1]
                 && wdata_q[`DADC_STAT_CLIP_A + i])
          clip_seen_q[i] <= 1'b0;
      end
    end
  end

  // Snapshot handshake: copy holds once the link has answered, control rides along
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ack_s1_q <= 1'b0;
      ack_s2_q <= 1'b0;
      snap_req_q <= 1'b0;
      snap_a_q <= '0;
      snap_b_q <= '0;
      snap_stat_q <= '0;
      ctrl_xfer_q <= `DADC_CTRL_RST;
    end
    else
    begin
      ack_s1_q <= link_ack_q;
      ack_s2_q <= ack_s1_q;
      if (ack_s2_q == snap_req_q)
      begin
        snap_a_q <= hold_a_q;
        snap_b_q <= hold_b_q;
        snap_stat_q <= hold_stat_q;
        ctrl_xfer_q <= ctrl_q;
        snap_req_q <= ~snap_req_q;
      end
    end
  end

  always_comb
  begin
    rd_hit = 1'b1;
    rd_word = '0;
    case ({s_axi_araddr[31:2], 2'b00})
      `DADC_A_CTRL: rd_word[`DADC_CTRL_W-1:0] = ctrl_q;
      `DADC_A_STATUS:
      begin
        rd_word[`DADC_STAT_W-1:0] = snap_stat_q;
        rd_word[`DADC_STAT_CLIP_B:`DADC_STAT_CLIP_A] = clip_seen_q;
      end
      `DADC_A_WORD_A: rd_word[`DADC_W-1:0] = snap_a_q;
      `DADC_A_WORD_B: rd_word[`DADC_W-1:0] = snap_b_q;
      default: rd_hit = 1'b0;
    endcase
  end

  // Read address and data
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rd_state_q <= dadc_pkg::DADC_RD_IDLE;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= `DADC_RESP_OKAY;
    end
    else
    begin
      case (rd_state_q)
        dadc_pkg::DADC_RD_IDLE:
        begin
          if (s_axi_arvalid && s_axi_arready)
          begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_hit ? `DADC_RESP_OKAY : `DADC_RESP_SLVERR;
            rd_state_q <= dadc_pkg::DADC_RD_RESP;
          end
          else
            s_axi_arready <= 1'b1;
        end
        dadc_pkg::DADC_RD_RESP:
        begin
          if (s_axi_rready)
          begin
            s_axi_rvalid <= 1'b0;
            rd_state_q <= dadc_pkg::DADC_RD_IDLE;
          end
        end
        default:
          rd_state_q <= dadc_pkg::DADC_RD_IDLE;
      endcase
    end
  end

  // Reset and pin synchronisers on the sample clock
  always_ff @(posedge link_clk)
  begin
    lrst_s1_q <= aresetn;
    lrst_s2_q <= lrst_s1_q;
  end

  assign link_rst_n = lrst_s2_q;

  always_ff @(posedge link_clk)
  begin
    if (!link_rst_n)
    begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
    end
    else
    begin
      pin_s1_q <= {sleep_chan_b, sleep_chan_a, format_stabiliser_select};
      pin_s2_q <= pin_s1_q;
    end
  end

  assign lvl_sel = lctrl_q[`DADC_CTRL_OVR]
    ? dadc_pkg::dadc_level_t'(lctrl_q[`DADC_CTRL_LVL_HI:`DADC_CTRL_LVL_LO])
    : dadc_pkg::dadc_level_t'(pin_s2_q[1:0]);

  // Mode decode and per-channel sleep
  always_ff @(posedge link_clk)
  begin
    if (!link_rst_n)
    begin
      mode_q <= '0;
      sleep_q <= '0;
    end
    else
    begin
      mode_q.lvl <= lvl_sel;
      case (lvl_sel)
        dadc_pkg::DADC_LVL_SUPPLY: {mode_q.twos, mode_q.stab} <= 2'h2;
        dadc_pkg::DADC_LVL_GND: {mode_q.twos, mode_q.stab} <= 2'h0;
        dadc_pkg::DADC_LVL_TWOTHIRD: {mode_q.twos, mode_q.stab} <= 2'h3;
        dadc_pkg::DADC_LVL_THIRD: {mode_q.twos, mode_q.stab} <= 2'h1;
        default: {mode_q.twos, mode_q.stab} <= 2'h0;
      endcase
      sleep_q[0] <= pin_s2_q[2] | lctrl_q[`DADC_CTRL_SLP_A];
      sleep_q[1] <= pin_s2_q[3] | lctrl_q[`DADC_CTRL_SLP_B];
    end
  end

  always_ff @(posedge link_clk)
  begin
    if (!link_rst_n)
      stat_q <= '0;
    else
      stat_q <= {mode_q.lvl, mode_q.stab, mode_q.twos, sleep_q};
  end

  assign ch_in[0] = analog_in_a;
  assign ch_in[1] = analog_in_b;

  generate
    for (genvar c = 0; c < `DADC_NCH; c++)
    begin : g_chan
      dadc_chan u_chan (
        .link_clk(link_clk),
        .link_rst_n(link_rst_n),
        .cfg('{sleep: sleep_q[c], twos: mode_q.twos}),
        .analog_in(ch_in[c]),
        .result_word(ch_word[c]),
        .clip(ch_clip[c])
      );
    end
  endgenerate

  assign result_word_a = ch_word[0];
  assign result_word_b = ch_word[1];

  // Link half of the snapshot handshake
  always_ff @(posedge link_clk)
  begin
    if (!link_rst_n)
    begin
      req_s1_q <= 1'b0;
      req_s2_q <= 1'b0;
      link_ack_q <= 1'b0;
      hold_a_q <= '0;
      hold_b_q <= '0;
      hold_clip_q <= '0;
      clip_acc_q <= '0;
      lctrl_q <= `DADC_CTRL_RST;
      hold_stat_q <= '0;
    end
    else
    begin
      req_s1_q <= snap_req_q;
      req_s2_q <= req_s1_q;
      if (req_s2_q != link_ack_q)
      begin
        hold_a_q <= ch_word[0];
        hold_b_q <= ch_word[1];
        hold_clip_q <= clip_acc_q | ch_clip;
        lctrl_q <= ctrl_xfer_q;
        hold_stat_q <= stat_q;
        clip_acc_q <= '0;
        link_ack_q <= req_s2_q;
      end
      else
        clip_acc_q <= clip_acc_q | ch_clip;
    end
  end

  // Strobe: high after rising edge, low after falling edge
  always_ff @(posedge link_clk)
  begin
    if (!link_rst_n)
      stb_pos_q <= 1'b0;
    else
      stb_pos_q <= ~stb_pos_q;
  end

  always_ff @(negedge link_clk)
  begin
    if (!link_rst_n)
      stb_neg_q <= 1'b0;
    else
      stb_neg_q <= stb_pos_q;
  end

  assign word_valid_strobe = stb_pos_q ^ stb_neg_q;

endmodule : dadc_top

// File: bench/dadc_checker.sv
`timescale 1ns/1ps
`include "dadc_defines.svh"

module dadc_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic link_clk,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic [`DADC_IN_W-1:0] analog_in_a,
  input wire logic [`DADC_IN_W-1:0] analog_in_b,
  input wire logic sleep_chan_a,
  input wire logic sleep_chan_b,
  input wire logic [`DADC_W-1:0] result_word_a,
  input wire logic [`DADC_W-1:0] result_word_b,
  input wire logic word_valid_strobe
);
  logic [2:0] live_q;
  logic [`DADC_W-1:0] rise_a_q;
  logic [`DADC_W-1:0] rise_b_q;

  // Link side settled some cycles after reset release
  always_ff @(posedge link_clk)
  begin
    if (!aresetn)
      live_q <= 3'h0;
    else if (live_q != 3'h7)
      live_q <= live_q + 3'h1;
  end

  always_ff @(posedge link_clk)
  begin
    rise_a_q <= result_word_a;
    rise_b_q <= result_word_b;
  end

  sequence s_sleep_a;
    sleep_chan_a [*7];
  endsequence
  sequence s_sleep_b;
    sleep_chan_b [*7];
  endsequence
  sequence s_clip_hi;
    (($signed(analog_in_a) > $signed(`DADC_POS_FS)) && !sleep_chan_a) [*6];
  endsequence
  sequence s_clip_lo;
    (($signed(analog_in_b) < $signed(`DADC_NEG_FS)) && !sleep_chan_b) [*6];
  endsequence

  AST_STROBE_HIGH_AT_FALL: assert property (@(negedge link_clk) disable iff (!aresetn)
    (live_q == 3'h7) |-> word_valid_strobe) else $error("strobe low before link fall");
  AST_STROBE_LOW_AT_RISE: assert property (@(posedge link_clk) disable iff (!aresetn)
    (live_q == 3'h7) |-> !word_valid_strobe) else $error("strobe high before link rise");
  AST_WORD_STEADY_HIGH: assert property (@(negedge link_clk) disable iff (!aresetn)
    (live_q == 3'h7) |-> (result_word_a == rise_a_q) && (result_word_b == rise_b_q))
    else $error("word changed while strobe high");
  AST_SLEEP_A_ZERO: assert property (@(posedge link_clk) disable iff (!aresetn)
    s_sleep_a |-> result_word_a == `DADC_CODE_MIN) else $error("asleep word a not zero");
  AST_SLEEP_B_ZERO: assert property (@(posedge link_clk) disable iff (!aresetn)
    s_sleep_b |-> result_word_b == `DADC_CODE_MIN) else $error("asleep word b not zero");
  AST_CLIP_HIGH: assert property (@(posedge link_clk) disable iff (!aresetn)
    s_clip_hi |-> result_word_a inside {12'hfff, 12'h7ff}) else $error("no top code");
  AST_CLIP_LOW: assert property (@(posedge link_clk) disable iff (!aresetn)
    s_clip_lo |-> result_word_b inside {12'h000, 12'h800}) else $error("no bottom code");
  AST_WRITE_ANSWERED: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  AST_READ_ANSWERED: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid) else $error("read data late");
  AST_ONE_READ: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid |-> !s_axi_arready) else $error("second read accepted");
endmodule : dadc_checker

// File: bench/dadc_capture.sv
`timescale 1ns/1ps
`include "dadc_defines.svh"

module dadc_capture (
  input wire logic word_valid_strobe,
  input wire logic [`DADC_W-1:0] result_word_a,
  input wire logic [`DADC_W-1:0] result_word_b,
  output logic [`DADC_W-1:0] cap_a,
  output logic [`DADC_W-1:0] cap_b
);
  always_ff @(posedge word_valid_strobe)
  begin
    cap_a <= result_word_a;
    cap_b <= result_word_b;
  end
endmodule : dadc_capture

// File: bench/testbench.sv
`timescale 1ns/1ps
`include "dadc_defines.svh"

module testbench;
  logic aclk = 1'b0, link_clk = 1'b0, aresetn = 1'b0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, word_valid_strobe;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] s_axi_rdata, rdat;
  logic [`DADC_IN_W-1:0] analog_in_a = 14'h0000, analog_in_b = 14'h0000;
  logic [1:0] format_stabiliser_select = 2'h0;
  logic sleep_chan_a = 1'b0, sleep_chan_b = 1'b0;
  logic [`DADC_W-1:0] result_word_a, result_word_b, cap_a, cap_b;
  int num_errors = 0;
  int checks_done = 0;

  always #20 aclk = ~aclk;
  initial
  begin
    #7;
    forever #40 link_clk = ~link_clk;
  end

  dadc_top u_dadc_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .link_clk(link_clk), .analog_in_a(analog_in_a),
    .analog_in_b(analog_in_b), .format_stabiliser_select(format_stabiliser_select),
    .sleep_chan_a(sleep_chan_a), .sleep_chan_b(sleep_chan_b), .result_word_a(result_word_a),
    .result_word_b(result_word_b), .word_valid_strobe(word_valid_strobe));

  dadc_capture u_dadc_capture (.word_valid_strobe(word_valid_strobe), .result_word_a(result_word_a),
    .result_word_b(result_word_b), .cap_a(cap_a), .cap_b(cap_b));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic results;
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : results

  function automatic logic [11:0] ew(input int v, input logic tw);
    int o;
    o = v + 2048;
    if (o > 4095)
      o = 4095;
    if (o < 0)
      o = 0;
    return 12'(o) ^ {tw, 11'h000};
  endfunction : ew

  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    fork
      begin
        do @(posedge aclk); while (!s_axi_awready);
        s_axi_awvalid <= 1'b0;
      end
      begin
        do @(posedge aclk); while (!s_axi_wready);
        s_axi_wvalid <= 1'b0;
      end
    join
    while (!s_axi_bvalid) @(posedge aclk);
    resp = s_axi_bresp;
  endtask : wr

  task automatic rd(input logic [31:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    rdat = s_axi_rdata;
    resp = s_axi_rresp;
  endtask : rd

  task automatic settle;
    repeat (20) @(posedge link_clk);
  endtask : settle

  task automatic setin(input int a, input int b);
    @(posedge link_clk);
    analog_in_a <= 14'(a);
    analog_in_b <= 14'(b);
  endtask : setin

  initial
  begin
    #200000;
    num_errors++;
    results;
  end

  initial
  begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (8) @(posedge link_clk);
    rd(`DADC_A_CTRL);
    chk(rdat, 32'h0);
    rd(32'h0000_0010);
    chk(resp, `DADC_RESP_SLVERR);
    wr(`DADC_A_WORD_A, 32'h1, 4'hf);
    chk(resp, `DADC_RESP_SLVERR);
    setin(291, -5);
    for (int i = 0; i < 4; i++)
    begin
      format_stabiliser_select <= 2'(i);
      settle;
      chk(cap_a, ew(291, i[1]));
      chk(cap_b, ew(-5, i[1]));
      rd(`DADC_A_STATUS);
      chk(rdat[5:2], {2'(i), (i == 1 || i == 2), i[1]});
    end
    rd(`DADC_A_WORD_A);
    chk(rdat, {20'h0, ew(291, 1'b1)});
    rd(`DADC_A_WORD_B);
    chk(rdat, {20'h0, ew(-5, 1'b1)});
    format_stabiliser_select <= 2'h0;
    settle;
    setin(100, -5);
    repeat (4) @(posedge link_clk);
    #1 chk(cap_a, ew(291, 1'b0));
    @(posedge link_clk);
    #1 chk(cap_a, ew(100, 1'b0));
    setin(5000, -5000);
    settle;
    chk(cap_a, 12'hfff);
    chk(cap_b, 12'h000);
    rd(`DADC_A_STATUS);
    chk(rdat[9:8], 2'b11);
    setin(0, 0);
    settle;
    wr(`DADC_A_STATUS, 32'h300, 4'h2);
    rd(`DADC_A_STATUS);
    chk(rdat[9:8], 2'b00);
    sleep_chan_a <= 1'b1;
    settle;
    chk(cap_a, 12'h000);
    chk(cap_b, 12'h800);
    rd(`DADC_A_STATUS);
    chk(rdat[1:0], 2'b01);
    sleep_chan_a <= 1'b0;
    sleep_chan_b <= 1'b1;
    settle;
    chk(cap_a, 12'h800);
    chk(cap_b, 12'h000);
    sleep_chan_b <= 1'b0;
    setin(300, 300);
    wr(`DADC_A_CTRL, 32'h1e, 4'h1);
    settle;
    chk(cap_b, 12'h000);
    chk(cap_a, ew(300, 1'b1));
    rd(`DADC_A_STATUS);
    chk(rdat[5:2], 4'b1101);
    wr(`DADC_A_CTRL, 32'h0, 4'he);
    rd(`DADC_A_CTRL);
    chk(rdat, 32'h1e);
    wr(`DADC_A_CTRL, 32'h1, 4'h1);
    settle;
    chk(cap_b, ew(300, 1'b0));
    chk(cap_a, 12'h000);
    results;
  end
endmodule : testbench

bind dadc_top dadc_checker u_dadc_checker (.aclk(aclk), .aresetn(aresetn), .link_clk(link_clk),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .analog_in_a(analog_in_a),
  .analog_in_b(analog_in_b), .sleep_chan_a(sleep_chan_a), .sleep_chan_b(sleep_chan_b),
  .result_word_a(result_word_a), .result_word_b(result_word_b), .word_valid_strobe(word_valid_strobe));
